// file: hw/cam_mode_ctrl.sv
/*
 * Counter array mode register and timebase generator. Holds the 8-bit
 * mode register, picks one of seven count sources, gates counting during
 * CPU idle, drives the watchdog enable and the overflow interrupt request.
 * Assumes the counter, its overflow flag and the watchdog compare logic
 * live elsewhere on the same clock; pins and oscillators arrive unsynced.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Idle suspend bit halts counting during CPU idle
// - Watchdog enable makes module five the watchdog
// - Watchdog enable is set after every reset
// - Lock keeps watchdog enabled until next reset
// - Codes 000,001,100: sysclk div 12, 4, 1
// - Code 010 counts timer 0 overflows
// - Code 011 counts external input falling edges
// - Codes 101,110: oscillator div 8, synchronised
// - Overflow interrupt enable gates overflow flag request
// - Watchdog enabled freezes timebase and idle bits
module cam_mode_ctrl (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_cpu_idle,
    input wire logic i_timer0_ovf,
    input wire logic i_ext_count_in,
    input wire logic i_ext_osc_clk,
    input wire logic i_rtc_osc_clk,
    input wire logic i_counter_overflow_flag,
    output logic [7:0] o_sfr_rdata,
    output logic o_count_tick,
    output logic o_array_run,
    output logic o_watchdog_active,
    output logic o_irq_req
);

    ////////////////////////////////////////////////////////////////////////
    // Mode register fields
    logic idle_suspend_r; // Halt during idle
    logic watchdog_enable_r; // Module five is watchdog
    logic watchdog_lock_r; // Sticky until reset
    logic [2:0] timebase_select_r; // Count source
    logic overflow_irq_enable_r; // Overflow request mask
    logic mode_wr; // Write strobe decoded
    logic mode_rd; // Read strobe decoded

    assign mode_wr = i_sfr_wr && (i_sfr_addr == cam_pkg::MODE_ADDR);
    assign mode_rd = i_sfr_rd && (i_sfr_addr == cam_pkg::MODE_ADDR);

    // Watchdog enable and lock; setting lock also enables the watchdog
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            watchdog_enable_r <= cam_pkg::MODE_RESET[cam_pkg::BIT_WATCHDOG_ENABLE];
            watchdog_lock_r <= cam_pkg::MODE_RESET[cam_pkg::BIT_WATCHDOG_LOCK];
        end else if (mode_wr) begin
            // Lock can only be set by software, never cleared
            watchdog_lock_r <= watchdog_lock_r
                || i_sfr_wdata[cam_pkg::BIT_WATCHDOG_LOCK];
            // A locked watchdog ignores attempts to clear its enable
            watchdog_enable_r <= watchdog_lock_r
                || i_sfr_wdata[cam_pkg::BIT_WATCHDOG_LOCK]
                || i_sfr_wdata[cam_pkg::BIT_WATCHDOG_ENABLE];
        end
    end

    // Timebase and idle bits, frozen while the watchdog is running
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            idle_suspend_r <= cam_pkg::MODE_RESET[cam_pkg::BIT_IDLE_SUSPEND];
            timebase_select_r <= cam_pkg::MODE_RESET[cam_pkg::BIT_TB_HI:cam_pkg::BIT_TB_LO];
        end else if (mode_wr && !watchdog_enable_r) begin
            // Old enable value decides, so disable-and-reconfigure needs two writes
            idle_suspend_r <= i_sfr_wdata[cam_pkg::BIT_IDLE_SUSPEND];
            timebase_select_r <= i_sfr_wdata[cam_pkg::BIT_TB_HI:cam_pkg::BIT_TB_LO];
        end
    end

    // Overflow interrupt mask, always writable
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            overflow_irq_enable_r <= cam_pkg::MODE_RESET[cam_pkg::BIT_OVF_IRQ_ENABLE];
        end else if (mode_wr) begin
            overflow_irq_enable_r <= i_sfr_wdata[cam_pkg::BIT_OVF_IRQ_ENABLE];
        end
    end

    // Registered read data; bit 4 is never stored and reads zero
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sfr_rdata <= 8'h00;
        end else if (mode_rd) begin
            o_sfr_rdata <= {idle_suspend_r, watchdog_enable_r, watchdog_lock_r,
                            1'b0, timebase_select_r, overflow_irq_enable_r};
        end else begin
            o_sfr_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: pin and both oscillators pass two flops
    logic [2:0] cin_sync_r; // [0] meta, [1] stable, [2] previous
    logic [2:0] ext_sync_r;
    logic [2:0] rtc_sync_r;

    // Oscillators are sampled, so they must run well below half of i_mclk
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cin_sync_r <= 3'h7;
            ext_sync_r <= 3'h0;
            rtc_sync_r <= 3'h0;
        end else begin
            cin_sync_r <= {cin_sync_r[1:0], i_ext_count_in};
            ext_sync_r <= {ext_sync_r[1:0], i_ext_osc_clk};
            rtc_sync_r <= {rtc_sync_r[1:0], i_rtc_osc_clk};
        end
    end

    logic cin_fall; // Falling edge of external count input
    logic ext_rise; // Rising edge of external oscillator
    logic rtc_rise; // Rising edge of real-time oscillator

    assign cin_fall = cin_sync_r[2] && !cin_sync_r[1];
    assign ext_rise = !ext_sync_r[2] && ext_sync_r[1];
    assign rtc_rise = !rtc_sync_r[2] && rtc_sync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Free-running prescalers
    logic [3:0] div12_r;
    logic [1:0] div4_r;
    logic [2:0] ext_div_r;
    logic [2:0] rtc_div_r;

    // System clock prescalers never stop, so a tick is exactly periodic
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            div12_r <= 4'h0;
            div4_r <= 2'h0;
        end else begin
            div12_r <= (div12_r == cam_pkg::DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
            div4_r <= div4_r + 2'h1;
        end
    end

    // Oscillator dividers count synchronised edges
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_div_r <= 3'h0;
            rtc_div_r <= 3'h0;
        end else begin
            if (ext_rise) begin
                ext_div_r <= ext_div_r + 3'h1;
            end
            if (rtc_rise) begin
                rtc_div_r <= rtc_div_r + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection and idle gating
    logic src_tick; // Selected source fires this cycle
    logic run_now; // Array not halted by idle

    assign run_now = !(idle_suspend_r && i_cpu_idle);

    // Reserved code 111 yields no ticks at all
    always_comb begin
        unique case (timebase_select_r)
            cam_pkg::TB_SYS_DIV12: src_tick = (div12_r == cam_pkg::DIV12_LAST);
            cam_pkg::TB_SYS_DIV4: src_tick = (div4_r == cam_pkg::DIV4_LAST);
            cam_pkg::TB_TIMER0_OVF: src_tick = i_timer0_ovf;
            cam_pkg::TB_EXT_INPUT: src_tick = cin_fall;
            cam_pkg::TB_SYS: src_tick = 1'b1;
            cam_pkg::TB_EXT_OSC_DIV8: src_tick = ext_rise && (ext_div_r == cam_pkg::DIV8_LAST);
            cam_pkg::TB_RTC_DIV8: src_tick = rtc_rise && (rtc_div_r == cam_pkg::DIV8_LAST);
            default: src_tick = 1'b0;
        endcase
    end

    // Registered outputs: tick, run, watchdog and interrupt request
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_count_tick <= 1'b0;
            o_array_run <= 1'b0;
            o_watchdog_active <= 1'b0;
            o_irq_req <= 1'b0;
        end else begin
            o_count_tick <= src_tick && run_now;
            o_array_run <= run_now;
            o_watchdog_active <= watchdog_enable_r;
            o_irq_req <= overflow_irq_enable_r && i_counter_overflow_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    // Gap since the last tick; a counter stands in for a long repetition
    logic [3:0] tick_gap_r; // Cycles since last tick, saturates
    logic tb_div12_r; // Divide by 12 was selected one cycle ago
    logic div12_held_r; // Divide by 12 held since last tick

    // Any source change restarts the check, since prescaler phase is free
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_gap_r <= 4'hF;
            tb_div12_r <= 1'b0;
            div12_held_r <= 1'b0;
        end else begin
            tb_div12_r <= (timebase_select_r == cam_pkg::TB_SYS_DIV12);
            if (o_count_tick) begin
                // Previous tick must itself come from the divide by 12 source
                tick_gap_r <= 4'h0;
                div12_held_r <= tb_div12_r && (timebase_select_r == cam_pkg::TB_SYS_DIV12);
            end else begin
                tick_gap_r <= (tick_gap_r == 4'hF) ? 4'hF : tick_gap_r + 4'h1;
                if (timebase_select_r != cam_pkg::TB_SYS_DIV12) begin
                    div12_held_r <= 1'b0;
                end
            end
        end
    end

    sequence s_tick_div12;
        o_count_tick && $past(timebase_select_r) == cam_pkg::TB_SYS_DIV12 && div12_held_r;
    endsequence

    a_idle_halt: assert property (idle_suspend_r && i_cpu_idle |=> !o_count_tick && !o_array_run)
        else $error("count tick while idle suspended");
    a_idle_keep: assert property (!idle_suspend_r && timebase_select_r == cam_pkg::TB_SYS
                                  |=> o_count_tick)
        else $error("undivided clock did not tick without suspend");
    a_wd_follow: assert property ($past(i_resetn)
                                  |-> o_watchdog_active == $past(watchdog_enable_r))
        else $error("watchdog output does not follow enable");
    a_lock_hold: assert property (watchdog_lock_r |-> watchdog_enable_r ##1 watchdog_lock_r)
        else $error("locked watchdog lost enable or lock");
    a_div12_gap: assert property (s_tick_div12 |-> tick_gap_r >= cam_pkg::DIV12_LAST)
        else $error("divide by 12 ticks too close");
    a_div4_gap: assert property (o_count_tick && $past(timebase_select_r) == cam_pkg::TB_SYS_DIV4
                                 |=> (!o_count_tick) [*3])
        else $error("divide by 4 ticks too close");
    a_timer0_tick: assert property (i_timer0_ovf && run_now
                                    && timebase_select_r == cam_pkg::TB_TIMER0_OVF
                                    |=> o_count_tick)
        else $error("timer 0 overflow missed");
    a_pin_tick: assert property (cin_sync_r[2] && !cin_sync_r[1] && run_now
                                 && timebase_select_r == cam_pkg::TB_EXT_INPUT
                                 |=> o_count_tick)
        else $error("external falling edge missed");
    a_irq_gate: assert property (o_irq_req == $past(overflow_irq_enable_r && i_counter_overflow_flag))
        else $error("interrupt request not gated by enable");
    a_freeze: assert property (watchdog_enable_r && mode_wr
                               |=> $stable(timebase_select_r) && $stable(idle_suspend_r))
        else $error("frozen field changed with watchdog on");
    a_unused_zero: assert property (!o_sfr_rdata[cam_pkg::BIT_UNUSED])
        else $error("unused bit reads one");

endmodule // cam_mode_ctrl

`default_nettype wire

// file: hw/cam_pkg.sv
/*
 * Constants for the counter array mode control block: register address,
 * field positions, value after reset, timebase codes and prescaler counts.
 * Assumes a single system clock domain and an 8-bit special function bus.
 */
package cam_pkg;

    // Register address on the special function bus
    localparam logic [7:0] MODE_ADDR = 8'hD9;
    // Value after reset: only the watchdog enable is set
    localparam logic [7:0] MODE_RESET = 8'h40;

    // Field positions inside counter_array_mode
    localparam int BIT_IDLE_SUSPEND = 7;
    localparam int BIT_WATCHDOG_ENABLE = 6;
    localparam int BIT_WATCHDOG_LOCK = 5;
    localparam int BIT_UNUSED = 4;
    localparam int BIT_TB_HI = 3;
    localparam int BIT_TB_LO = 1;
    localparam int BIT_OVF_IRQ_ENABLE = 0;

    // Timebase select codes
    localparam logic [2:0] TB_SYS_DIV12 = 3'h0;
    localparam logic [2:0] TB_SYS_DIV4 = 3'h1;
    localparam logic [2:0] TB_TIMER0_OVF = 3'h2;
    localparam logic [2:0] TB_EXT_INPUT = 3'h3;
    localparam logic [2:0] TB_SYS = 3'h4;
    localparam logic [2:0] TB_EXT_OSC_DIV8 = 3'h5;
    localparam logic [2:0] TB_RTC_DIV8 = 3'h6;

    // Prescaler terminal counts (divisor minus one)
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;

endpackage

// file: verif/cam_mode_ctrl_tb.sv
/*
 * Self-checking bench for the counter array mode control block.
 * Assumes one 40 MHz clock, strobes driven at the falling edge and
 * read data valid the cycle after the read strobe is taken.
 */
`timescale 1ns/1ps
`default_nettype none

module cam_mode_ctrl_tb;

    logic i_mclk = 1'b0; // System clock
    logic i_resetn = 1'b0; // Active low reset
    logic wr = 1'b0; // Write strobe
    logic rd = 1'b0; // Read strobe
    logic idle = 1'b0; // CPU idle level
    logic t0 = 1'b0; // Timer 0 overflow pulse
    logic cin = 1'b1; // External count pin, idles high
    logic flag = 1'b0; // Counter overflow flag
    logic [7:0] addr = 8'h00; // Register address
    logic [7:0] wdata = 8'h00; // Write data
    logic [1:0] ph = 2'h0; // Oscillator phase, mclk/4 rate
    logic [7:0] rdata; // Read data
    logic tick; // Counter advance
    logic run; // Array not halted
    logic wda; // Watchdog active
    logic irq; // Interrupt request
    int err_total = 0; // Mismatch count
    int checked = 0; // Comparison count
    // Ticks per 96-cycle window for codes 0 to 7
    logic [7:0] exp_tb [8] = '{8'h08, 8'h18, 8'h05, 8'h05, 8'h60, 8'h03, 8'h03, 8'h00};

    ////////////////////////////////////////////////////////////////////////
    // Clock and free-running oscillators, slow enough for any sampler
    always #12.5 i_mclk = ~i_mclk;
    always @(negedge i_mclk) ph <= ph + 2'h1;

    cam_mode_ctrl u_cam_mode_ctrl (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wdata), .i_cpu_idle(idle), .i_timer0_ovf(t0),
        .i_ext_count_in(cin), .i_ext_osc_clk(ph[1]), .i_rtc_osc_clk(ph[1]),
        .i_counter_overflow_flag(flag), .o_sfr_rdata(rdata), .o_count_tick(tick),
        .o_array_run(run), .o_watchdog_active(wda), .o_irq_req(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compare, bus and measurement tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits a falling edge first so a strobe is never set twice at once
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_mclk);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_mclk);
        addr = a;
        rd = 1'b1;
        @(negedge i_mclk);
        rd = 1'b0;
        chk("mode read", exp, rdata);
    endtask

    // Events only in the first 40 cycles, so late latency never spills out
    task automatic count(input int n, input logic [7:0] exp);
        logic [7:0] c;
        c = 8'h00;
        repeat (8) @(negedge i_mclk);
        for (int k = 0; k < n; k++) begin
            @(negedge i_mclk);
            cin = !(k < 40 && k % 8 >= 4);
            t0 = (k < 40 && k % 8 == 0);
            if (tick === 1'b1) c++;
        end
        cin = 1'b1;
        t0 = 1'b0;
        chk("tick count", exp, c);
    endtask

    task automatic wrap_up();
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(negedge i_mclk);
        i_resetn = 1'b1;
        rd_reg(cam_pkg::MODE_ADDR, cam_pkg::MODE_RESET);
        chk("watchdog active", 8'h01, {7'h00, wda});
        wr_reg(cam_pkg::MODE_ADDR, 8'hC8);
        rd_reg(cam_pkg::MODE_ADDR, 8'h40);
        wr_reg(cam_pkg::MODE_ADDR, 8'h10);
        rd_reg(cam_pkg::MODE_ADDR, 8'h00);
        chk("watchdog active", 8'h00, {7'h00, wda});
        wr_reg(8'hD8, 8'hFF);
        rd_reg(8'hD8, 8'h00);
        rd_reg(cam_pkg::MODE_ADDR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr_reg(cam_pkg::MODE_ADDR, {4'h0, i[2:0], 1'b0});
            count(96, exp_tb[i]);
        end
        // Idle with and without suspension, system clock timebase
        wr_reg(cam_pkg::MODE_ADDR, 8'h88);
        idle = 1'b1;
        count(96, 8'h00);
        chk("array run", 8'h00, {7'h00, run});
        wr_reg(cam_pkg::MODE_ADDR, 8'h08);
        count(96, 8'h60);
        chk("array run", 8'h01, {7'h00, run});
        idle = 1'b0;
        // Interrupt request follows enable and flag
        wr_reg(cam_pkg::MODE_ADDR, 8'h09);
        flag = 1'b1;
        repeat (2) @(negedge i_mclk);
        chk("irq request", 8'h01, {7'h00, irq});
        wr_reg(cam_pkg::MODE_ADDR, 8'h08);
        repeat (2) @(negedge i_mclk);
        chk("irq request", 8'h00, {7'h00, irq});
        flag = 1'b0;
        // Lock enables and cannot be undone by a write
        wr_reg(cam_pkg::MODE_ADDR, 8'h20);
        rd_reg(cam_pkg::MODE_ADDR, 8'h60);
        wr_reg(cam_pkg::MODE_ADDR, 8'h00);
        rd_reg(cam_pkg::MODE_ADDR, 8'h60);
        chk("watchdog active", 8'h01, {7'h00, wda});
        // Second reset clears the lock and sets the enable again
        @(negedge i_mclk);
        i_resetn = 1'b0;
        repeat (3) @(negedge i_mclk);
        i_resetn = 1'b1;
        rd_reg(cam_pkg::MODE_ADDR, cam_pkg::MODE_RESET);
        wrap_up();
    end

endmodule // cam_mode_ctrl_tb

`default_nettype wire
